// file: include/sync_ctrl_pkg.sv
// package: register map, field positions, codes, timing counts and state types of the sync slave
package sync_ctrl_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0] ADDR_OUTPUT_DISABLE  = 7'h01;
  localparam logic [6:0] ADDR_PHASE_STATUS    = 7'h0d;
  localparam logic [6:0] ADDR_SYNC_CONTROL    = 7'h10;
  localparam logic [6:0] ADDR_MANUAL_ROTATE   = 7'h11;
  localparam logic [6:0] ADDR_RX_DELAY_START  = 7'h12;
  localparam logic [6:0] ADDR_SMP_DELAY_START = 7'h13;
  localparam logic [6:0] ADDR_RX_DELAY_FOUND  = 7'h14;
  localparam logic [6:0] ADDR_PEER_DELAY      = 7'h15;
  localparam logic [6:0] ADDR_SEARCH_STATUS   = 7'h16;

  localparam logic [7:0] SLAVE_ENABLE_CODE  = 8'h50;
  localparam logic [7:0] MASTER_ENABLE_CODE = 8'h70;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [7:0] DELAY_START_RESET  = 8'h40;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OUT_DISABLE_BIT = 5;
  localparam int QUAD_FLAG_BIT   = 5;
  localparam int ZERO_FLAG_BIT   = 4;
  localparam int ALIGNED_BIT     = 3;
  localparam int ROTATE_REQ_BIT  = 0;
  localparam int SRCH_LOCK_BIT   = 0;
  localparam int SRCH_FAIL_BIT   = 1;
  localparam int MISALIGN_BIT    = 2;

  // serial frame: read flag, 7 address bits, 8 data bits
  localparam logic [3:0] FRAME_HDR_LAST  = 4'h7;
  localparam logic [3:0] FRAME_DATA_LAST = 4'hf;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int ROTATE_SETTLE_NS = 32;
  localparam int TAP_SETTLE_NS    = 40;
  localparam logic [3:0] ROTATE_SETTLE_CYC =
    4'((ROTATE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [3:0] TAP_SETTLE_CYC =
    4'((TAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // delay taps per data period of four converter clocks; tap size is a board matter
  localparam logic [7:0] DATA_PERIOD_TAPS = 8'h10;
  localparam logic [7:0] SEARCH_SPAN      = 8'h40;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [2:0] {SYNC_IDLE, SYNC_WAIT_REF, SYNC_ROTATE, SYNC_SETTLE, SYNC_ALIGNED}
    sync_state_t;
  typedef enum logic [2:0] {SRCH_SETTLE, SRCH_TEST, SRCH_NEXT, SRCH_LOCKED, SRCH_FAIL}
    search_state_t;

endpackage : sync_ctrl_pkg

// file: hw/quad_phase_divider.sv
// divide-by-4 phase generator with single-step rotation
`timescale 1ns/100ps
`default_nettype none
module quad_phase_divider (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       rotate,
  // phases and current setting
  output logic [3:0]      phases,
  output logic [1:0]      phase_sel
);
  import sync_ctrl_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] sel;
    logic [3:0] ph;
  } div_st_t;

  div_st_t    st;
  div_st_t    next_st;
  logic [1:0] lag;

  always_comb begin
    next_st = st;
    lag     = 2'h0;
    // holding the count for one cycle delays every phase by one converter clock
    if (rotate) begin
      next_st.sel = st.sel + 2'h1;
    end else begin
      next_st.cnt = st.cnt + 2'h1;
    end
    for (int k = 0; k < 4; k++) begin
      // phase k lags phase 0 by k converter clocks
      lag           = next_st.cnt - 2'(k);
      next_st.ph[k] = ~lag[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phases    = st.ph;
  assign phase_sel = st.sel;
endmodule : quad_phase_divider
`default_nettype wire

// file: hw/multichip_sync_slave_controller.sv
// slave multichip sync controller: serial register port, phase alignment, delay search
`timescale 1ns/100ps
`default_nettype none
module multichip_sync_slave_controller (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // serial register port
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe,
  // sync reference
  input  wire logic       sync_ref_in,
  output logic            sync_ref_out,
  // data clock
  output logic            source_clock_output,
  // receive delay line
  input  wire logic       delay_edge_valid,
  output logic [7:0]      receive_clock_delay,
  output logic [7:0]      sampling_delay
);
  import sync_ctrl_pkg::*;

  typedef struct packed {
    logic          sclk_q;
    logic          ref_q;
    logic [3:0]    bit_cnt;
    logic [14:0]   in_sh;
    logic [7:0]    out_sh;
    logic          is_read;
    logic [6:0]    addr;
    logic          sdo;
    logic          sdo_oe;
    logic [7:0]    out_disable;
    logic [7:0]    sync_control;
    logic [7:0]    rx_start;
    logic [7:0]    smp_start;
    logic [7:0]    peer_delay;
    sync_state_t   sync_state;
    logic          quad_flag;
    logic          zero_flag;
    logic [3:0]    settle_cnt;
    logic          rotate;
    search_state_t srch_state;
    logic [7:0]    tap;
    logic [7:0]    smp_tap;
    logic [7:0]    mag;
    logic          dir_down;
    logic [3:0]    srch_cnt;
    logic [7:0]    found;
    logic          misaligned;
    logic [1:0]    clk_div;
    logic          src_clk;
    logic          ref_out;
  } ctrl_st_t;

  ctrl_st_t   st;
  ctrl_st_t   next_st;
  logic [3:0] phases;
  logic [1:0] phase_sel;

  quad_phase_divider u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .rotate    (st.rotate),
    .phases    (phases),
    .phase_sel (phase_sel)
  );

  // ****************************************************************
  // register read decode
  // ****************************************************************
  function automatic logic [7:0] read_reg(input ctrl_st_t s, input logic [6:0] a,
                                          input logic [1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADDR_OUTPUT_DISABLE:  v = s.out_disable;
      ADDR_PHASE_STATUS: begin
        v[QUAD_FLAG_BIT] = s.quad_flag;
        v[ZERO_FLAG_BIT] = s.zero_flag;
        v[ALIGNED_BIT]   = (s.sync_state == SYNC_ALIGNED);
        v[1:0]           = sel;
      end
      ADDR_SYNC_CONTROL:    v = s.sync_control;
      ADDR_RX_DELAY_START:  v = s.rx_start;
      ADDR_SMP_DELAY_START: v = s.smp_start;
      ADDR_RX_DELAY_FOUND:  v = s.found;
      ADDR_PEER_DELAY:      v = s.peer_delay;
      ADDR_SEARCH_STATUS: begin
        v[SRCH_LOCK_BIT] = (s.srch_state == SRCH_LOCKED);
        v[SRCH_FAIL_BIT] = (s.srch_state == SRCH_FAIL);
        v[MISALIGN_BIT]  = s.misaligned;
      end
      default:              v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ****************************************************************
  // next state
  // ****************************************************************
  logic       sclk_rise;
  logic       sclk_fall;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       slave_en;
  logic       ref_rise;
  logic       in_window;
  logic [8:0] cand;
  logic [7:0] diff;

  always_comb begin
    next_st   = st;
    sclk_rise = spi_sclk & ~st.sclk_q;
    sclk_fall = ~spi_sclk & st.sclk_q;
    wr_stb    = 1'b0;
    wr_data   = {st.in_sh[6:0], spi_sdi};
    slave_en  = (st.sync_control == SLAVE_ENABLE_CODE);
    ref_rise  = sync_ref_in & ~st.ref_q;
    // reference rose after the 0 degree edge and before the 90 degree edge
    in_window = phases[0] & ~phases[1];
    cand      = 9'h000;
    diff      = 8'h00;
    next_st.sclk_q = spi_sclk;
    next_st.ref_q  = sync_ref_in;
    next_st.rotate = 1'b0;

    // serial frame: bits shift in on sclk rise, read data shifts out on sclk fall
    if (spi_cs_n) begin
      next_st.bit_cnt = 4'h0;
      next_st.sdo_oe  = 1'b0;
    end else if (sclk_rise) begin
      next_st.in_sh   = {st.in_sh[13:0], spi_sdi};
      next_st.bit_cnt = st.bit_cnt + 4'h1;
      if (st.bit_cnt == FRAME_HDR_LAST) begin
        next_st.is_read = st.in_sh[6];
        next_st.addr    = {st.in_sh[5:0], spi_sdi};
        if (st.in_sh[6]) begin
          next_st.out_sh = read_reg(st, {st.in_sh[5:0], spi_sdi}, phase_sel);
        end
      end
      wr_stb = (st.bit_cnt == FRAME_DATA_LAST) & ~st.is_read;
    end else if (sclk_fall && st.is_read && st.bit_cnt > FRAME_HDR_LAST) begin
      next_st.sdo    = st.out_sh[7];
      next_st.sdo_oe = 1'b1;
      next_st.out_sh = {st.out_sh[6:0], 1'b0};
    end

    if (wr_stb) begin
      unique case (st.addr)
        ADDR_OUTPUT_DISABLE:  next_st.out_disable  = wr_data;
        ADDR_SYNC_CONTROL:    next_st.sync_control = wr_data;
        ADDR_MANUAL_ROTATE:   next_st.rotate = wr_data[ROTATE_REQ_BIT] & ~slave_en;
        ADDR_RX_DELAY_START: begin
          next_st.rx_start   = wr_data;
          // a new start value restarts the edge search from it
          next_st.tap        = wr_data;
          next_st.smp_tap    = st.smp_start;
          next_st.mag        = 8'h00;
          next_st.dir_down   = 1'b1;
          next_st.srch_cnt   = 4'h0;
          next_st.srch_state = SRCH_SETTLE;
        end
        ADDR_SMP_DELAY_START: next_st.smp_start  = wr_data;
        ADDR_PEER_DELAY:      next_st.peer_delay = wr_data;
        default: ;
      endcase
    end

    // ****************************************************************
    // phase alignment
    // ****************************************************************
    if (!slave_en) begin
      next_st.sync_state = SYNC_IDLE;
    end else begin
      unique case (st.sync_state)
        SYNC_IDLE:     next_st.sync_state = SYNC_WAIT_REF;
        SYNC_WAIT_REF, SYNC_ALIGNED: begin
          if (ref_rise) begin
            next_st.quad_flag  = ~phases[1];
            next_st.zero_flag  = ~phases[0];
            next_st.sync_state = in_window ? SYNC_ALIGNED : SYNC_ROTATE;
          end
        end
        SYNC_ROTATE: begin
          next_st.rotate     = 1'b1;
          next_st.settle_cnt = ROTATE_SETTLE_CYC;
          next_st.sync_state = SYNC_SETTLE;
        end
        SYNC_SETTLE: begin
          // let the new phase run before judging the next reference edge
          next_st.settle_cnt = st.settle_cnt - 4'h1;
          if (st.settle_cnt == 4'h1) begin
            next_st.sync_state = SYNC_WAIT_REF;
          end
        end
      endcase
    end

    // ****************************************************************
    // receive delay search: start, +1, -1, +2, -2 ... until an edge is seen or the step reaches SEARCH_SPAN
    // ****************************************************************
    unique case (st.srch_state)
      SRCH_SETTLE: begin
        next_st.srch_cnt = st.srch_cnt + 4'h1;
        if (st.srch_cnt == TAP_SETTLE_CYC - 4'h1) begin
          next_st.srch_state = SRCH_TEST;
        end
      end
      SRCH_TEST: begin
        if (delay_edge_valid) begin
          next_st.found      = st.tap;
          next_st.srch_state = SRCH_LOCKED;
        end else begin
          next_st.srch_state = SRCH_NEXT;
        end
      end
      SRCH_NEXT: begin
        next_st.dir_down = ~st.dir_down;
        if (st.dir_down) begin
          next_st.mag = st.mag + 8'h01;
          cand = {1'b0, st.rx_start} + {1'b0, st.mag} + 9'h001;
        end else begin
          cand = {1'b0, st.rx_start} - {1'b0, st.mag};
        end
        next_st.srch_cnt = 4'h0;
        if (st.mag >= SEARCH_SPAN) begin
          next_st.srch_state = SRCH_FAIL;
        end else if (!cand[8]) begin
          next_st.tap        = cand[7:0];
          next_st.smp_tap    = st.smp_start + cand[7:0] - st.rx_start;
          next_st.srch_state = SRCH_SETTLE;
        end
      end
      SRCH_LOCKED, SRCH_FAIL: ;
    endcase

    diff = (st.found > st.peer_delay) ? st.found - st.peer_delay : st.peer_delay - st.found;
    next_st.misaligned = (st.srch_state == SRCH_LOCKED) && (diff > DATA_PERIOD_TAPS);

    // ****************************************************************
    // outputs
    // ****************************************************************
    next_st.clk_div = st.clk_div + 2'h1;
    next_st.src_clk = st.clk_div[1] & ~st.out_disable[OUT_DISABLE_BIT];
    next_st.ref_out = phases[0] & ~st.out_disable[OUT_DISABLE_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st              <= '0;
      st.sync_state   <= SYNC_IDLE;
      st.srch_state   <= SRCH_SETTLE;
      st.dir_down     <= 1'b1;
      st.out_disable  <= REG_RESET;
      st.sync_control <= REG_RESET;
      st.rx_start     <= DELAY_START_RESET;
      st.smp_start    <= DELAY_START_RESET;
      st.tap          <= DELAY_START_RESET;
      st.smp_tap      <= DELAY_START_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign spi_sdo             = st.sdo;
  assign spi_sdo_oe          = st.sdo_oe;
  assign sync_ref_out        = st.ref_out;
  assign source_clock_output = st.src_clk;
  assign receive_clock_delay = st.tap;
  assign sampling_delay      = st.smp_tap;
endmodule : multichip_sync_slave_controller
`default_nettype wire

// file: testbench/sync_master_model.sv
// master-side stand-in: shared reference at clk/4 and the delay-line probe
`timescale 1ns/100ps
`default_nettype none
module sync_master_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bench controls
  input  wire logic       ref_run,
  input  wire logic [1:0] skew,
  input  wire logic [7:0] good_tap,
  // slave side
  input  wire logic [7:0] tap,
  output logic            ref_out,
  output logic            edge_ok
);
  logic [1:0] cnt;
  logic [1:0] pos;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  // skew delays the reference by whole clocks so the slave must re-rotate
  assign pos = cnt - skew;
  assign ref_out = ref_run & pos[1];
  // a single usable tap gives the search exactly one answer
  assign edge_ok = (tap == good_tap);
endmodule : sync_master_model
`default_nettype wire

// file: testbench/multichip_sync_slave_controller_chk.sv
// checker: port timing of the sync slave
`timescale 1ns/100ps
`default_nettype none
module sync_slave_chk (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // observed ports
  input wire logic       spi_cs_n,
  input wire logic       spi_sclk,
  input wire logic       spi_sdo,
  input wire logic       spi_sdo_oe,
  input wire logic       sync_ref_out,
  input wire logic       source_clock_output,
  input wire logic       delay_edge_valid,
  input wire logic [7:0] receive_clock_delay,
  input wire logic [7:0] sampling_delay
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] offs;
  logic [3:0] low_cnt;
  assign offs = sampling_delay - receive_clock_delay;
  // a running clk/4 is never low longer than two cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 4'h0;
    else if (source_clock_output) low_cnt <= 4'h0;
    else if (low_cnt != 4'hf) low_cnt <= low_cnt + 4'h1;
  end
  oe_off_a: assert property (spi_cs_n |=> !spi_sdo_oe) else $error("sdo enable with frame off");
  oe_rise_a: assert property ($rose(spi_sdo_oe) |-> !$past(spi_cs_n))
    else $error("sdo enable outside a frame");
  sdo_hold_a: assert property (spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo) |->
    ($past(spi_sclk, 3) && !$past(spi_sclk, 2)) || ($past(spi_sclk, 2) && !$past(spi_sclk)))
    else $error("sdo moved without a serial clock fall");
  dco_duty_a: assert property ($rose(source_clock_output) |-> ##2 !source_clock_output)
    else $error("data clock high too long");
  // a long low run may end with up to two free-running lows after re-enable,
  // so the reference is judged three samples back, inside the disabled stretch
  out_off_a: assert property (low_cnt > 4'h5 |-> !$past(sync_ref_out, 3))
    else $error("reference out running with data clock off");
  tap_hold_a: assert property ($changed(receive_clock_delay) |=>
    $stable(receive_clock_delay)[*5]) else $error("tap left before settling");
  smp_track_a: assert property ((spi_cs_n[*4] ##0 $changed(receive_clock_delay)) |->
    offs == $past(offs)) else $error("sample tap not tracking receive tap");
  tap_lock_a: assert property ((spi_cs_n && delay_edge_valid)[*8] |=>
    $stable(receive_clock_delay)) else $error("search moved off a valid tap");
  cover property ($rose(spi_sdo_oe));
  cover property (low_cnt == 4'h8);
  cover property ((spi_cs_n && delay_edge_valid)[*8]);
endmodule : sync_slave_chk
bind multichip_sync_slave_controller sync_slave_chk chk (.clk(clk), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .sync_ref_out(sync_ref_out), .source_clock_output(source_clock_output),
  .delay_edge_valid(delay_edge_valid), .receive_clock_delay(receive_clock_delay),
  .sampling_delay(sampling_delay));
`default_nettype wire

// file: testbench/tb_multichip_sync_slave_controller.sv
// testbench: registers, phase alignment, output disable, delay search
`timescale 1ns/100ps
`default_nettype none
module tb_multichip_sync_slave_controller;
  import sync_ctrl_pkg::*;
  logic clk, rst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, got, ref_run;
  logic sync_ref_in, sync_ref_out, source_clock_output, delay_edge_valid;
  logic [1:0] skew;
  logic [7:0] receive_clock_delay, sampling_delay, good_tap, got_val, rd_val, p, v, d, s;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int miscompares = 0, num_checks = 0, cycles = 0, seed;
  multichip_sync_slave_controller uut (.clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .sync_ref_in(sync_ref_in), .sync_ref_out(sync_ref_out),
    .source_clock_output(source_clock_output), .delay_edge_valid(delay_edge_valid),
    .receive_clock_delay(receive_clock_delay), .sampling_delay(sampling_delay));
  sync_master_model far (.clk(clk), .rst_n(rst_n), .ref_run(ref_run), .skew(skew),
    .good_tap(good_tap), .tap(receive_clock_delay), .ref_out(sync_ref_in),
    .edge_ok(delay_edge_valid));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // each serial level lasts two clocks so the edge detector sees it
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] dat);
    logic [15:0] f;
    f = {r, a, dat};
    @(posedge clk) spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) spi_sclk <= 1'b0;
      spi_sdi <= f[i];
      @(posedge clk);
      @(posedge clk) spi_sclk <= 1'b1;
      @(posedge clk);
      #1 rd_val = {rd_val[6:0], spi_sdo};
    end
    @(posedge clk) spi_cs_n <= 1'b1;
    spi_sclk <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] dat);
    xfer(1'b0, a, dat);
  endtask : wr
  // note the expectation and hand the seen value to the comparing process
  task automatic post(input logic [7:0] seen, input logic [7:0] want, input logic [7:0] m);
    exp_q.push_back({m, want & m});
    got_val <= seen;
    got <= 1'b1;
    @(posedge clk) got <= 1'b0;
  endtask : post
  task automatic rd(input logic [6:0] a, input logic [7:0] want, input logic [7:0] m);
    xfer(1'b1, a, 8'h00);
    post(rd_val, want, m);
  endtask : rd
  task automatic note(input string t);
    $display("test %s finished, %0d checks so far", t, num_checks);
  endtask : note
  always @(posedge clk) begin
    if (got) begin
      e = exp_q.pop_front();
      check(got_val & e[15:8], e[7:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // whole run is a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    seed = 32'h31df;
    rst_n = 1'b0;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
    ref_run = 1'b0;
    skew = 2'h0;
    good_tap = 8'h3d;
    got = 1'b0;
    got_val = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_OUTPUT_DISABLE, 8'h00, 8'hff);
    rd(ADDR_SYNC_CONTROL, 8'h00, 8'hff);
    rd(7'h7f, 8'h00, 8'hff);
    rd(ADDR_MANUAL_ROTATE, 8'h00, 8'hff);
    note("reset");
    // search from 0x40 visits 40,41,3f,42,3e,43,3d
    rd(ADDR_RX_DELAY_FOUND, 8'h3d, 8'hff);
    rd(ADDR_SEARCH_STATUS, 8'h01, 8'h03);
    post(sampling_delay, 8'h3d, 8'hff);
    wr(ADDR_PEER_DELAY, 8'h4e);
    rd(ADDR_SEARCH_STATUS, 8'h04, 8'h04);
    wr(ADDR_PEER_DELAY, 8'h2d);
    rd(ADDR_SEARCH_STATUS, 8'h00, 8'h04);
    note("search");
    ref_run <= 1'b1;
    repeat (40) @(posedge clk);
    rd(ADDR_PHASE_STATUS, 8'h00, 8'h38);
    wr(ADDR_SYNC_CONTROL, MASTER_ENABLE_CODE);
    rd(ADDR_PHASE_STATUS, 8'h00, 8'h38);
    wr(ADDR_SYNC_CONTROL, SLAVE_ENABLE_CODE);
    repeat (40) @(posedge clk);
    rd(ADDR_PHASE_STATUS, 8'h28, 8'h38);
    p = rd_val;
    wr(ADDR_MANUAL_ROTATE, 8'h01);
    rd(ADDR_PHASE_STATUS, p, 8'h3b);
    wr(ADDR_SYNC_CONTROL, REG_RESET);
    skew <= 2'h2;
    repeat (40) @(posedge clk);
    // the aligned bit follows the machine, which rests while disabled
    rd(ADDR_PHASE_STATUS, p, 8'h33);
    wr(ADDR_MANUAL_ROTATE, 8'h01);
    rd(ADDR_PHASE_STATUS, {p[7:2], p[1:0] + 2'h1}, 8'h33);
    wr(ADDR_SYNC_CONTROL, SLAVE_ENABLE_CODE);
    repeat (40) @(posedge clk);
    rd(ADDR_PHASE_STATUS, {p[7:2], p[1:0] + 2'h2}, 8'h3b);
    note("align");
    v = 8'($random(seed)) | 8'h20;
    wr(ADDR_OUTPUT_DISABLE, v);
    rd(ADDR_OUTPUT_DISABLE, v, 8'hff);
    repeat (8) begin
      @(negedge clk);
      post({6'h00, source_clock_output, sync_ref_out}, 8'h00, 8'hff);
    end
    wr(ADDR_OUTPUT_DISABLE, v & 8'hdf);
    s = 8'h00;
    repeat (8) begin
      @(negedge clk);
      s = s | {6'h00, source_clock_output, sync_ref_out};
    end
    post(s, 8'h03, 8'hff);
    note("outputs");
    d = 8'($random(seed)) & 8'h07;
    good_tap <= 8'h4d + d;
    wr(ADDR_SMP_DELAY_START, 8'h30);
    wr(ADDR_RX_DELAY_START, 8'h50);
    repeat (80) @(posedge clk);
    rd(ADDR_RX_DELAY_FOUND, 8'h4d + d, 8'hff);
    post(sampling_delay, 8'h2d + d, 8'hff);
    good_tap <= 8'h00;
    wr(ADDR_RX_DELAY_START, 8'h50);
    repeat (1000) @(posedge clk);
    rd(ADDR_SEARCH_STATUS, 8'h02, 8'h03);
    note("restart");
    @(posedge clk);
    test_done();
  end
endmodule : tb_multichip_sync_slave_controller
`default_nettype wire
